// ---- design/t2c_pkg.sv ----
// constants for the timer 2 capture/reload counter block
package t2c_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_CONTROL  = 8'hc8;
   localparam logic [7:0] IDX_MODE     = 8'hc9;
   localparam logic [7:0] IDX_RCAP_LO  = 8'hca;
   localparam logic [7:0] IDX_RCAP_HI  = 8'hcb;
   localparam logic [7:0] IDX_COUNT_LO = 8'hcc;
   localparam logic [7:0] IDX_COUNT_HI = 8'hcd;
   localparam logic [7:0] IDX_IRQ_STS  = 8'hd0;
   localparam logic [7:0] IDX_IRQ_MSK  = 8'hd1;
   localparam logic [7:0] IDX_AUX_CFG  = 8'hd2;

   // timer2_control field positions
   localparam int CTL_OVF   = 7;
   localparam int CTL_EXF   = 6;
   localparam int CTL_RCLK  = 5;
   localparam int CTL_SERIAL_TRANSMIT_CLOCK_SELECT  = 4;
   localparam int CTL_EXEN  = 3;
   localparam int CTL_RUN   = 2;
   localparam int CTL_CT    = 1;
   localparam int CTL_CPRL  = 0;

   // timer2_mode_control field positions
   localparam int MOD_HC_LO = 4;
   localparam int MOD_HC_HI = 7;
   localparam int MOD_CRST  = 3;
   localparam int MOD_DOWN_COUNT_ENABLE  = 0;
   localparam logic [7:0] MOD_WMASK = 8'hf9;

   // interrupt status / mask bits
   localparam int STS_OVF = 0;
   localparam int STS_EXT = 1;

   // reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // count limits
   localparam logic [15:0] CNT_MAX  = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   // clocks per tick: baud mode, timer fast, timer slow
   localparam logic [3:0] BAUD_DIV = 4'h2;
   localparam logic [3:0] FAST_DIV = 4'h4;
   localparam logic [3:0] SLOW_DIV = 4'hc;

endpackage

// ---- design/t2c_timer.sv ----
// timer 2 counter with capture, auto-reload, up/down and wishbone registers
`timescale 1ns/10ps
`default_nettype none

// bus side: one classic cycle per register access
// request taken on the edge where cyc and stb are high and ack is low
// ack stands for exactly one cycle after that edge; read data holds until the next request
// ack high in the following cycle keeps a held request from being taken twice
// only byte lane 0 carries data; other lanes are ignored
// unmapped indices read zero and still acknowledge, so software never hangs
// sixteen-bit count and reload go as two bytes with no latch; a running
// count read byte by byte may tear, stop the timer first if that matters
//
// pin side: both pins pass two synchroniser stages and one compare stage
// a fall is seen three edges after the pin drops; a pin must be sampled low
// on at least one edge or the fall may be lost
//
// interrupt side: status bits are sticky, cleared by writing ones;
// a hardware set in the same cycle as a clear wins so no event is lost
// the interrupt output is registered from the next status and mask, so it changes on the same edge as the status

module t2c_timer (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // pins
   input  wire logic        external_trigger_pin_i,
   input  wire logic        count_input_pin_i,
   // external interrupts 2..5 service entry
   input  wire logic [3:0]  ext_int_isr_entry_i,
   output logic      [3:0]  ext_int_hw_clear_o,
   // serial port baud tick and timer interrupt
   output logic             baud_overflow_o,
   output logic             irq_o
);

   // operating mode, derived each cycle from the control bits
   typedef enum logic [1:0] {
      T2C_BAUD    = 2'b00,
      T2C_CAPTURE = 2'b01,
      T2C_RELOAD  = 2'b10,
      T2C_UPDOWN  = 2'b11
   } t2c_mode_t;

   // whole state of the block
   // ctl and mode mirror the two control registers bit for bit
   // rcap doubles as capture target and reload source
   // trg_s and cin_s are the pin synchronisers plus the compare stage
   // presc divides the clock down to the timer tick
   // ack, dat, irq, baud_ovf and hwclr feed the outputs directly,
   // so every output comes straight from a flop
   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  mode;
      logic [15:0] rcap;
      logic [15:0] cnt;
      logic        speed;
      logic [1:0]  sts;
      logic [1:0]  msk;
      logic [2:0]  trg_s;
      logic [2:0]  cin_s;
      logic [3:0]  presc;
      logic        ack;
      logic [31:0] dat;
      logic        irq;
      logic        baud_ovf;
      logic [3:0]  hwclr;
   } t2c_state_t;

   t2c_state_t q;
   t2c_state_t d;

   // register index match, used by both read and write decode
   function automatic logic t2c_hit(input logic [9:0] adr, input logic [7:0] idx);
      t2c_hit = (adr[9:2] == idx);
   endfunction

   logic        req;
   logic        wr;
   logic        baud;
   logic        trg_fall;
   logic        cin_fall;
   logic        trg_act;
   logic        tick;
   logic        tf_set;
   logic        exf_set;
   logic [3:0]  div;
   logic [7:0]  wbyte;
   logic [7:0]  rbyte;
   t2c_mode_t   md;

   // next-state logic
   always_comb begin
      d        = q;
      d.ack    = 1'b0;
      d.baud_ovf = 1'b0;
      tick     = 1'b0;
      tf_set   = 1'b0;
      exf_set  = 1'b0;
      rbyte    = rst_byte_f();
      wbyte    = wb_dat_i[7:0];
      req      = wb_cyc_i & wb_stb_i & ~q.ack;
      wr       = req & wb_we_i & wb_sel_i[0];

      // first stage feeds only the second; edges seen on stages 1 and 2
      d.trg_s  = {q.trg_s[1:0], external_trigger_pin_i};
      d.cin_s  = {q.cin_s[1:0], count_input_pin_i};
      trg_fall = q.trg_s[2] & ~q.trg_s[1];
      cin_fall = q.cin_s[2] & ~q.cin_s[1];

      baud = q.ctl[t2c_pkg::CTL_RCLK] | q.ctl[t2c_pkg::CTL_SERIAL_TRANSMIT_CLOCK_SELECT];
      if (baud) begin
         md = T2C_BAUD;
      end else if (q.ctl[t2c_pkg::CTL_CPRL]) begin
         md = T2C_CAPTURE;
      end else if (q.mode[t2c_pkg::MOD_DOWN_COUNT_ENABLE]) begin
         md = T2C_UPDOWN;
      end else begin
         md = T2C_RELOAD;
      end

      // tick source; prescaler held at zero while stopped
      div = baud ? t2c_pkg::BAUD_DIV : (q.speed ? t2c_pkg::FAST_DIV : t2c_pkg::SLOW_DIV);
      if (!q.ctl[t2c_pkg::CTL_RUN]) begin
         d.presc = 4'h0;
      end else if (q.ctl[t2c_pkg::CTL_CT] && !baud) begin
         tick = cin_fall;
      end else if (q.presc == (div - 4'h1)) begin
         d.presc = 4'h0;
         tick    = 1'b1;
      end else begin
         d.presc = q.presc + 4'h1;
      end

      // counting; no tick leaves the count untouched
      // overflow is detected on the all-ones value before the increment,
      // so the wrap and the flag land on the same edge as the reload
      // down counting compares against the reload value, not zero,
      // which lets software set the lower bound of the count
      if (tick) begin
         case (md)
            T2C_BAUD: begin
               if (q.cnt == t2c_pkg::CNT_MAX) begin
                  d.cnt      = q.rcap;
                  d.baud_ovf = 1'b1;
               end else begin
                  d.cnt = q.cnt + 16'h0001;
               end
            end
            T2C_CAPTURE: begin
               if (q.cnt == t2c_pkg::CNT_MAX) begin
                  d.cnt  = t2c_pkg::CNT_ZERO;
                  tf_set = 1'b1;
               end else begin
                  d.cnt = q.cnt + 16'h0001;
               end
            end
            T2C_RELOAD: begin
               if (q.cnt == t2c_pkg::CNT_MAX) begin
                  d.cnt  = q.rcap;
                  tf_set = 1'b1;
               end else begin
                  d.cnt = q.cnt + 16'h0001;
               end
            end
            T2C_UPDOWN: begin
               // trigger level high counts up, low counts down
               if (q.trg_s[2]) begin
                  if (q.cnt == t2c_pkg::CNT_MAX) begin
                     d.cnt   = q.rcap;
                     tf_set  = 1'b1;
                     exf_set = 1'b1;
                  end else begin
                     d.cnt = q.cnt + 16'h0001;
                  end
               end else if (q.cnt == q.rcap) begin
                  d.cnt   = t2c_pkg::CNT_MAX;
                  tf_set  = 1'b1;
                  exf_set = 1'b1;
               end else begin
                  d.cnt = q.cnt - 16'h0001;
               end
            end
            default: begin
               d.cnt = q.cnt;
            end
         endcase
      end

      // trigger edge: ignored unless enabled; direction input in up/down mode
      trg_act = trg_fall & q.ctl[t2c_pkg::CTL_EXEN] & (md != T2C_UPDOWN);
      if (trg_act) begin
         exf_set = 1'b1;
         if (md == T2C_CAPTURE) begin
            d.rcap = q.cnt;
            if (q.mode[t2c_pkg::MOD_CRST]) begin
               d.cnt = t2c_pkg::CNT_ZERO;
            end
         end else if (md == T2C_RELOAD) begin
            d.cnt = q.rcap;
         end
         // baud mode: flag only, no capture or reload
      end

      // software writes; a write to a count byte wins over counting
      // writes come after tick and trigger logic so they override both;
      // the flag sets below come later still and override a write
      // mode bits 2:1 are reserved and always read zero
      if (wr) begin
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_CONTROL)) begin
            d.ctl = wbyte;
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_MODE)) begin
            d.mode = wbyte & t2c_pkg::MOD_WMASK;
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_RCAP_LO)) begin
            d.rcap[7:0] = wbyte;
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_RCAP_HI)) begin
            d.rcap[15:8] = wbyte;
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_COUNT_LO)) begin
            d.cnt[7:0] = wbyte;
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_COUNT_HI)) begin
            d.cnt[15:8] = wbyte;
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_IRQ_STS)) begin
            d.sts = q.sts & ~wbyte[1:0]; // write one to clear
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_IRQ_MSK)) begin
            d.msk = wbyte[1:0];
         end
         if (t2c_hit(wb_adr_i, t2c_pkg::IDX_AUX_CFG)) begin
            d.speed = wbyte[0];
         end
      end

      // hardware sets win over a software clear in the same cycle
      if (tf_set) begin
         d.ctl[t2c_pkg::CTL_OVF]  = 1'b1;
         d.sts[t2c_pkg::STS_OVF]  = 1'b1;
      end
      if (exf_set) begin
         d.ctl[t2c_pkg::CTL_EXF]  = 1'b1;
         d.sts[t2c_pkg::STS_EXT]  = 1'b1;
      end
      d.irq = |(d.sts & d.msk);

      // auto-clear request for ext int 2..5 on service entry
      d.hwclr = ext_int_isr_entry_i & q.mode[t2c_pkg::MOD_HC_HI:t2c_pkg::MOD_HC_LO];

      // read mux; unmapped indices read zero and still acknowledge
      // data comes from the registered state, so a read in the same
      // cycle as an update returns the value before that update
      if (t2c_hit(wb_adr_i, t2c_pkg::IDX_CONTROL)) begin
         rbyte = q.ctl;
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_MODE)) begin
         rbyte = q.mode;
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_RCAP_LO)) begin
         rbyte = q.rcap[7:0];
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_RCAP_HI)) begin
         rbyte = q.rcap[15:8];
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_COUNT_LO)) begin
         rbyte = q.cnt[7:0];
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_COUNT_HI)) begin
         rbyte = q.cnt[15:8];
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_IRQ_STS)) begin
         rbyte = {6'h00, q.sts};
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_IRQ_MSK)) begin
         rbyte = {6'h00, q.msk};
      end else if (t2c_hit(wb_adr_i, t2c_pkg::IDX_AUX_CFG)) begin
         rbyte = {7'h00, q.speed};
      end
      if (req) begin
         d.ack = 1'b1;
         d.dat = {24'h000000, rbyte};
      end
   end

   // constant zero byte as a function keeps the read default named
   function automatic logic [7:0] rst_byte_f();
      rst_byte_f = t2c_pkg::RST_BYTE;
   endfunction

   // state register; synchronous reset to constants only
   // reset clears the synchronisers to low; the idle-high pins then
   // show a rise, never a fall, so no false trigger follows reset
   // every register runs on every edge; no enable gating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign wb_dat_o           = q.dat;
   assign wb_ack_o           = q.ack;
   assign irq_o              = q.irq;
   assign baud_overflow_o    = q.baud_ovf;
   assign ext_int_hw_clear_o = q.hwclr;

endmodule

`default_nettype wire

// ---- verification/t2c_timer_props.sv ----
// port-level checker for the timer 2 capture/reload counter
`timescale 1ns/10ps
`default_nettype none
module t2c_timer_props (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone side
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // events and interrupts
   input wire logic [3:0]  ext_int_isr_entry_i,
   input wire logic [3:0]  ext_int_hw_clear_o,
   input wire logic        baud_overflow_o,
   input wire logic        irq_o
);
   logic       take;
   logic [3:0] hc_q;
   logic [1:0] msk_q;
   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // shadow copies updated at the taking edge, so lag matches the registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hc_q  <= 4'h0;
         msk_q <= 2'h0;
      end else if (take & wb_we_i & wb_sel_i[0]) begin
         if (wb_adr_i[9:2] == t2c_pkg::IDX_MODE) hc_q <= wb_dat_i[7:4];
         if (wb_adr_i[9:2] == t2c_pkg::IDX_IRQ_MSK) msk_q <= wb_dat_i[1:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_follows_req: assert property (take |=> wb_ack_o) else $error("request not acked");
   chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   chk_ack_has_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
   chk_dat_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
   chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i[9:2] == 8'h00 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_hw_clear_gate: assert property (ext_int_hw_clear_o == ($past(ext_int_isr_entry_i) & $past(hc_q)))
      else $error("hardware clear mismatch");
   chk_baud_spacing: assert property (baud_overflow_o |=> !baud_overflow_o)
      else $error("baud ticks too close");
   chk_irq_masked: assert property (msk_q == 2'b00 |-> !irq_o)
      else $error("irq raised while masked");
endmodule
bind t2c_timer t2c_timer_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ext_int_isr_entry_i(ext_int_isr_entry_i), .ext_int_hw_clear_o(ext_int_hw_clear_o),
   .baud_overflow_o(baud_overflow_o), .irq_o(irq_o));
`default_nettype wire

// ---- verification/t2c_pin_model.sv ----
// pin-side model driving the trigger and count inputs
`timescale 1ns/10ps
`default_nettype none
module t2c_pin_model (
   // clock
   input  wire logic clk_i,
   // pin levels
   output var  logic trig_o,
   output var  logic cnt_o
);
   // both pins idle high so the first sampled level is never a fall
   initial begin
      trig_o = 1'b1;
      cnt_o  = 1'b1;
   end
   // each level held four clocks, longer than the synchroniser needs
   task automatic set_trig(input logic lvl);
      trig_o <= lvl;
      repeat (4) @(posedge clk_i);
   endtask
   // one falling edge on the trigger, then back high
   task automatic fall_trig();
      set_trig(1'b0);
      set_trig(1'b1);
   endtask
   // n falling edges on the count pin
   task automatic pulse_cnt(input int n);
      for (int i = 0; i < n; i++) begin
         cnt_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         cnt_o <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// ---- verification/t2c_timer_test.sv ----
// self-checking bench for the timer 2 capture/reload counter
`timescale 1ns/10ps
`default_nettype none
module t2c_timer_test;
   localparam logic [7:0] REGS [7] = '{t2c_pkg::IDX_CONTROL, t2c_pkg::IDX_MODE, t2c_pkg::IDX_RCAP_LO,
      t2c_pkg::IDX_RCAP_HI, t2c_pkg::IDX_COUNT_LO, t2c_pkg::IDX_COUNT_HI, 8'h00};
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, baud_o, trig, cnt;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, entry, hw_clr;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [7:0]  rv, v;
   int          fails, comparisons, cycles, seed, n, gap;
   t2c_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .external_trigger_pin_i(trig), .count_input_pin_i(cnt), .ext_int_isr_entry_i(entry),
      .ext_int_hw_clear_o(hw_clr), .baud_overflow_o(baud_o), .irq_o(irq_o));
   t2c_pin_model u_pins (.clk_i(clk_i), .trig_o(trig), .cnt_o(cnt));
   // free-running clock, 100 ns period
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // cycle ceiling, far above the several hundred cycles the run needs
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails = fails + 1;
         test_done();
      end
   end
   // clocks between baud ticks: ticks to wrap from lo, times the baud divider
   function automatic logic [7:0] gap_of(input logic [7:0] lo);
      return (8'h00 - lo) * {4'h0, t2c_pkg::BAUD_DIV};
   endfunction
   task automatic test_done();
      if (fails == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic cycle; held until ack is sampled high
   task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] wd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h0, wd};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rv = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      bus(idx, 1'b0, 8'h00);
      chk(rv, exp);
   endtask
   initial begin
      seed = 32'hfa77;
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, entry} = {1'b1, 49'h0};
      wb_sel_i = 4'hf;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) rd(REGS[i], 8'h00);
      // byte lane 0 off: write ignored
      wb_sel_i <= 4'he;
      bus(t2c_pkg::IDX_COUNT_LO, 1'b1, 8'h55);
      wb_sel_i <= 4'hf;
      rd(t2c_pkg::IDX_COUNT_LO, 8'h00);
      // random hardware-clear enables against random service entries
      for (int i = 0; i < 6; i++) begin
         v = 8'($random(seed));
         bus(t2c_pkg::IDX_MODE, 1'b1, v);
         rd(t2c_pkg::IDX_MODE, v & t2c_pkg::MOD_WMASK);
         entry <= v[3:0];
         @(posedge clk_i);
         entry <= 4'h0;
         @(negedge clk_i);
         chk({4'h0, hw_clr}, {4'h0, v[7:4] & v[3:0]});
         @(negedge clk_i);
         chk({4'h0, hw_clr}, 8'h00);
      end
      // overflow in reload mode: both bytes reloaded, flag and irq raised
      bus(t2c_pkg::IDX_MODE, 1'b1, 8'h00);
      bus(t2c_pkg::IDX_IRQ_MSK, 1'b1, 8'h01);
      bus(t2c_pkg::IDX_AUX_CFG, 1'b1, 8'h01);
      bus(t2c_pkg::IDX_RCAP_LO, 1'b1, 8'h34);
      bus(t2c_pkg::IDX_RCAP_HI, 1'b1, 8'h12);
      bus(t2c_pkg::IDX_COUNT_LO, 1'b1, 8'hff);
      bus(t2c_pkg::IDX_COUNT_HI, 1'b1, 8'hff);
      bus(t2c_pkg::IDX_CONTROL, 1'b1, 8'h04);
      for (n = 0; irq_o !== 1'b1 && n < 50; n++) @(posedge clk_i);
      chk({7'h0, irq_o}, 8'h01);
      rd(t2c_pkg::IDX_CONTROL, 8'h84);
      rd(t2c_pkg::IDX_IRQ_STS, 8'h01);
      bus(t2c_pkg::IDX_CONTROL, 1'b1, 8'h00);
      rd(t2c_pkg::IDX_COUNT_HI, 8'h12);
      bus(t2c_pkg::IDX_COUNT_LO, 1'b0, 8'h00);
      chk({4'h0, rv[7:4]}, 8'h03);
      v = rv;
      repeat (20) @(posedge clk_i);
      rd(t2c_pkg::IDX_COUNT_LO, v);
      bus(t2c_pkg::IDX_IRQ_STS, 1'b1, 8'h03);
      repeat (2) @(posedge clk_i);
      chk({7'h0, irq_o}, 8'h00);
      // capture, capture with counter reset, and trigger ignored while disabled
      for (int k = 0; k < 3; k++) begin
         v = (8'($random(seed)) & 8'h7f) | 8'h01;
         bus(t2c_pkg::IDX_MODE, 1'b1, (k == 1) ? 8'h08 : 8'h00);
         bus(t2c_pkg::IDX_RCAP_HI, 1'b1, 8'h00);
         bus(t2c_pkg::IDX_COUNT_LO, 1'b1, 8'h00);
         bus(t2c_pkg::IDX_COUNT_HI, 1'b1, v);
         bus(t2c_pkg::IDX_CONTROL, 1'b1, (k == 2) ? 8'h05 : 8'h0d);
         u_pins.fall_trig();
         rd(t2c_pkg::IDX_CONTROL, (k == 2) ? 8'h05 : 8'h4d);
         rd(t2c_pkg::IDX_RCAP_HI, (k == 2) ? 8'h00 : v);
         rd(t2c_pkg::IDX_COUNT_HI, (k == 1) ? 8'h00 : v);
         chk({7'h0, irq_o}, 8'h00);
         bus(t2c_pkg::IDX_CONTROL, 1'b1, 8'h00);
         bus(t2c_pkg::IDX_IRQ_STS, 1'b1, 8'h03);
      end
      // counter mode counts falls on the count pin
      v = 8'($random(seed)) & 8'hf0;
      n = ($unsigned($random(seed)) % 8) + 1;
      bus(t2c_pkg::IDX_MODE, 1'b1, 8'h00);
      bus(t2c_pkg::IDX_COUNT_LO, 1'b1, v);
      bus(t2c_pkg::IDX_CONTROL, 1'b1, 8'h06);
      u_pins.pulse_cnt(n);
      rd(t2c_pkg::IDX_COUNT_LO, v + 8'(n));
      // down count with trigger low: match with reload value wraps to all ones
      bus(t2c_pkg::IDX_MODE, 1'b1, 8'h01);
      bus(t2c_pkg::IDX_RCAP_LO, 1'b1, 8'h00);
      bus(t2c_pkg::IDX_COUNT_LO, 1'b1, 8'h02);
      bus(t2c_pkg::IDX_COUNT_HI, 1'b1, 8'h00);
      u_pins.set_trig(1'b0);
      bus(t2c_pkg::IDX_CONTROL, 1'b1, 8'h04);
      repeat (20) @(posedge clk_i);
      rd(t2c_pkg::IDX_CONTROL, 8'hc4);
      bus(t2c_pkg::IDX_CONTROL, 1'b1, 8'h00);
      rd(t2c_pkg::IDX_COUNT_HI, 8'hff);
      u_pins.set_trig(1'b1);
      bus(t2c_pkg::IDX_MODE, 1'b1, 8'h00);
      // baud mode via either clock select, capture select set but ignored
      for (int k = 0; k < 2; k++) begin
         v = 8'($random(seed)) | 8'hf0;
         bus(t2c_pkg::IDX_RCAP_LO, 1'b1, v);
         bus(t2c_pkg::IDX_RCAP_HI, 1'b1, 8'hff);
         bus(t2c_pkg::IDX_COUNT_HI, 1'b1, 8'hff);
         bus(t2c_pkg::IDX_CONTROL, 1'b1, (k == 1) ? 8'h25 : 8'h15);
         while (baud_o !== 1'b1) @(posedge clk_i);
         gap = 0;
         do begin
            @(posedge clk_i);
            gap++;
         end while (baud_o !== 1'b1);
         chk(8'(gap), gap_of(v));
         bus(t2c_pkg::IDX_CONTROL, 1'b1, 8'h00);
      end
      test_done();
   end
endmodule
`default_nettype wire
